// file: gpcg_pkg.sv
`default_nettype none
package gpcg_pkg;
  localparam int GPCG_PORTS = 3;
  localparam int GPCG_W = 8;
  localparam int GPCG_AW = 8;
  // register offsets, index 0 = port B, 1 = port C, 2 = port D
  localparam logic [2:0][7:0] GPCG_DATA_OFS = {8'hA2, 8'h9E, 8'h9A};
  localparam logic [2:0][7:0] GPCG_DIR_OFS = {8'hA3, 8'h9F, 8'h9B};
  localparam logic [2:0][7:0] GPCG_SELA_OFS = {8'hA4, 8'hA0, 8'h9C};
  localparam logic [2:0][7:0] GPCG_SELB_OFS = {8'hA5, 8'hA1, 8'h9D};
  localparam logic [7:0] GPCG_GATE_OFS = 8'hDB;
  // gate bit of port B; C and D follow upward
  localparam int GPCG_GATE_B_BIT = 5;
  localparam logic [7:0] GPCG_GATE_WMASK = 8'hEF;
  localparam logic [7:0] GPCG_GATE_RST = 8'h00;
  localparam logic [7:0] GPCG_DATA_RST = 8'h00;
  localparam logic [7:0] GPCG_DIR_RST = 8'hFF;
  localparam logic [7:0] GPCG_SELA_RST = 8'h00;
  localparam logic [7:0] GPCG_SELB_RST = 8'h00;
  localparam logic [7:0] GPCG_ZERO = 8'h00;
  localparam logic [7:0] GPCG_ONES = 8'hFF;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpcg_bus_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } gpcg_drive_t;
endpackage
`default_nettype wire

// file: gpcg_top.sv
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RQ1: three identical 8-bit ports B, C, D give 24 pins.
// RQ2: pin mode comes from same bit of data, direction, select-a, select-b.
// RQ3: reading the data register returns synchronised pin levels.
// RQ4: reset leaves every pin a plain input with no interrupt.
// RQ5: mode 1 drives the data bit push-pull.
// RQ6: mode 2 releases the pin; it is an input.
// RQ7: mode 3 open-drain low on 0; mode 4 open-source high on 1.
// RQ8: mode 5 is reserved and releases the pin.
// RQ9: mode 6 releases pin, requests on both edges.
// RQ10: mode 7 hands value and enable to the alternate function.
// RQ11: mode 8 releases pin, level request low or high per data bit.
// RQ12: mode 9 releases pin, falling or rising edge per data bit.
// RQ13: reset clears all clock-gate bits.
// RQ14: gate bit 1 stops the peripheral, 0 restores it.
// RQ15: a gated port ignores register reads and writes.
// RQ16: gate bits 7, 6, 5 stop ports D, C, B.
// RQ17: in edge modes writing 1 clears the request, 0 does nothing.
// RQ18: level request needs level held two cycles, stays while held.
// RQ19: alternate function sees the pin only after synchronisation.
// RQ20: each pin has its own request line, only in interrupt modes.
module gpcg_top #(
  parameter int NUM_PORTS = gpcg_pkg::GPCG_PORTS,
  parameter int PORT_W = gpcg_pkg::GPCG_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire gpcg_pkg::gpcg_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in,
  output logic [NUM_PORTS-1:0][PORT_W-1:0] pin_out,
  output logic [NUM_PORTS-1:0][PORT_W-1:0] pin_oe_n,
  input wire gpcg_pkg::gpcg_drive_t [NUM_PORTS-1:0] alt_drive,
  output logic [NUM_PORTS-1:0][PORT_W-1:0] alt_in,
  output logic [NUM_PORTS-1:0][PORT_W-1:0] irq,
  output logic [7:0] gate_state
);

  // offsets and the gate map only exist for three byte-wide ports
  if (NUM_PORTS != gpcg_pkg::GPCG_PORTS || PORT_W != gpcg_pkg::GPCG_W) begin : g_chk
    $error("gpcg_top supports exactly three 8-bit ports");
  end

  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    logic r;
    r = 1'b0;
    if (addr == ofs) begin
      r = 1'b1;
    end
    return r;
  endfunction

  logic [7:0] gate_q;
  logic [7:0] gate_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_mux;
  logic gate_hit;
  logic [NUM_PORTS-1:0][7:0] port_rd;

  assign gate_hit = hit(bus_req.addr, gpcg_pkg::GPCG_GATE_OFS);

  // gate register is never gated itself, so a port can always be revived
  assign gate_d = (bus_req.wr && gate_hit)
    ? (bus_req.wdata & gpcg_pkg::GPCG_GATE_WMASK) : gate_q; // RQ14

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_q <= gpcg_pkg::GPCG_GATE_RST; // RQ13
    end else begin
      gate_q <= gate_d;
    end
  end

  always_comb begin
    rd_mux = gpcg_pkg::GPCG_ZERO;
    if (gate_hit) begin
      rd_mux = gate_q;
    end
    for (int i = 0; i < NUM_PORTS; i++) begin
      rd_mux = rd_mux | port_rd[i];
    end
  end

  // data only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= gpcg_pkg::GPCG_ZERO;
    end else if (bus_req.rd) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= gpcg_pkg::GPCG_ZERO;
    end
  end

  assign rd_data = rd_data_q;
  assign gate_state = gate_q;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port // RQ1
    logic port_on;
    logic hit_data;
    logic hit_dir;
    logic hit_sela;
    logic hit_selb;
    logic wr_data;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] prev_q;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] dir_q;
    logic [7:0] sela_q;
    logic [7:0] selb_q;
    logic [7:0] edge_q;
    logic [7:0] edge_d;
    logic [7:0] out_q;
    logic [7:0] oe_n_q;
    logic [7:0] alt_in_q;
    logic [7:0] irq_q;
    logic [7:0] m_push;
    logic [7:0] m_drain;
    logic [7:0] m_source;
    logic [7:0] m_dual;
    logic [7:0] m_alt;
    logic [7:0] m_level;
    logic [7:0] m_single;
    logic [7:0] m_edge;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] edge_set;
    logic [7:0] edge_clr;
    logic [7:0] level_req;
    logic [7:0] drive_en;
    logic [7:0] drive_val;

    assign port_on = ~gate_q[gpcg_pkg::GPCG_GATE_B_BIT + p]; // RQ16
    // a gated port answers nothing: reads give zero, writes are lost
    assign hit_data = port_on && hit(bus_req.addr, gpcg_pkg::GPCG_DATA_OFS[p]); // RQ15
    assign hit_dir = port_on && hit(bus_req.addr, gpcg_pkg::GPCG_DIR_OFS[p]); // RQ15
    assign hit_sela = port_on && hit(bus_req.addr, gpcg_pkg::GPCG_SELA_OFS[p]); // RQ15
    assign hit_selb = port_on && hit(bus_req.addr, gpcg_pkg::GPCG_SELB_OFS[p]); // RQ15
    assign wr_data = bus_req.wr && hit_data;

    assign port_rd[p] = hit_data ? sync2_q // RQ3
      : hit_dir ? dir_q
      : hit_sela ? sela_q
      : hit_selb ? selb_q
      : gpcg_pkg::GPCG_ZERO;

    // mode decode, bitwise per pin
    assign m_push = ~selb_q & ~sela_q & ~dir_q; // RQ2
    assign m_drain = ~selb_q & sela_q & ~dir_q;
    assign m_source = ~selb_q & sela_q & dir_q;
    assign m_dual = selb_q & ~sela_q & ~dir_q & data_q;
    assign m_alt = selb_q & ~sela_q & dir_q;
    assign m_level = selb_q & sela_q & ~dir_q;
    assign m_single = selb_q & sela_q & dir_q;
    assign m_edge = m_dual | m_single;

    // modes 2, 5, 6, 8, 9 fall through to released
    assign drive_en = m_push // RQ5
      | (m_drain & ~data_q) // RQ7
      | (m_source & data_q) // RQ7
      | (m_alt & ~alt_drive[p].oe_n); // RQ10
    assign drive_val = (m_alt & alt_drive[p].out) | (~m_alt & data_q); // RQ10

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;
    assign edge_set = (m_dual & (rise | fall)) // RQ9
      | (m_single & ((data_q & rise) | (~data_q & fall))); // RQ12
    assign edge_clr = wr_data ? bus_req.wdata : gpcg_pkg::GPCG_ZERO; // RQ17
    // set wins over a clear in the same cycle; leaving edge mode drops it
    assign edge_d = (edge_set | (edge_q & ~edge_clr)) & m_edge; // RQ20
    // two consecutive samples at the selected level
    assign level_req = m_level & ~(sync2_q ^ data_q) & ~(prev_q ^ data_q); // RQ18

    // in edge modes a 0 write neither clears nor moves the mode bit
    assign data_d = wr_data
      ? ((bus_req.wdata & ~m_edge) | ((data_q | bus_req.wdata) & m_edge)) // RQ17
      : data_q;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
      if (rst) begin
        sync1_q <= gpcg_pkg::GPCG_ZERO;
        sync2_q <= gpcg_pkg::GPCG_ZERO;
      end else begin
        sync1_q <= pin_in[p];
        sync2_q <= sync1_q;
      end
    end

    // a gated port freezes: no edges seen, outputs held
    always_ff @(posedge clk) begin
      if (rst) begin
        prev_q <= gpcg_pkg::GPCG_ZERO;
      end else if (port_on) begin
        prev_q <= sync2_q;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        data_q <= gpcg_pkg::GPCG_DATA_RST;
        dir_q <= gpcg_pkg::GPCG_DIR_RST; // RQ4
        sela_q <= gpcg_pkg::GPCG_SELA_RST; // RQ4
        selb_q <= gpcg_pkg::GPCG_SELB_RST; // RQ4
      end else begin
        data_q <= data_d;
        if (bus_req.wr && hit_dir) begin
          dir_q <= bus_req.wdata;
        end
        if (bus_req.wr && hit_sela) begin
          sela_q <= bus_req.wdata;
        end
        if (bus_req.wr && hit_selb) begin
          selb_q <= bus_req.wdata;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        edge_q <= gpcg_pkg::GPCG_ZERO;
        irq_q <= gpcg_pkg::GPCG_ZERO; // RQ4
      end else if (port_on) begin
        edge_q <= edge_d;
        irq_q <= edge_d | level_req; // RQ11
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        out_q <= gpcg_pkg::GPCG_ZERO;
        oe_n_q <= gpcg_pkg::GPCG_ONES; // RQ6
        alt_in_q <= gpcg_pkg::GPCG_ZERO;
      end else if (port_on) begin
        out_q <= drive_val;
        oe_n_q <= ~drive_en; // RQ8
        alt_in_q <= sync2_q; // RQ19
      end
    end

    assign pin_out[p] = out_q;
    assign pin_oe_n[p] = oe_n_q;
    assign alt_in[p] = alt_in_q;
    assign irq[p] = irq_q;
  end

endmodule // gpcg_top
`default_nettype wire

// file: gpcg_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpcg_pin_model (
  input wire logic [2:0][7:0] pin_out,
  input wire logic [2:0][7:0] pin_oe_n,
  input wire logic [2:0][7:0] ext,
  output logic [2:0][7:0] pin_in
);
  // released pins settle to the pull level; no keeper holds the old value
  assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule // gpcg_pin_model
`default_nettype wire

// file: gpcg_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module gpcg_top_sva #(
  parameter int NUM_PORTS = 3,
  parameter int PORT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire gpcg_pkg::gpcg_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in,
  input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_out,
  input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_oe_n,
  input wire logic [NUM_PORTS-1:0][PORT_W-1:0] irq,
  input wire logic [7:0] gate_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [7:0] a = bus_req.addr;
  wire logic mapped = (a >= 8'h9A && a <= 8'hA5) || a == 8'hDB;
  a_reset_quiet: assert property ($fell(rst) |-> !irq && &pin_oe_n && !gate_state)
    else $error("reset state wrong");
  a_rd_idle: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("rd_data not idle");
  a_gate_read: assert property (bus_req.rd && a == 8'hDB |=> rd_data == gate_state)
    else $error("gate read wrong");
  a_gate_write: assert property (bus_req.wr && a == 8'hDB
    |=> gate_state == ($past(bus_req.wdata) & 8'hEF)) else $error("gate write wrong");
  a_unmapped_zero: assert property (bus_req.rd && !mapped |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_irq_released: assert property ((irq & ~pin_oe_n) == '0)
    else $error("request on driven pin");
  // require two settled samples, so a synchroniser one stage shorter also passes
  a_sync_read: assert property (bus_req.rd && a == 8'h9A && !gate_state[5] && !$past(rst)
    && !$past(rst, 2) && $past(pin_in[0]) == $past(pin_in[0], 2)
    |=> rd_data == $past(pin_in[0], 3)) else $error("data read not pin level");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    a_gate_freeze: assert property (gate_state[5+p] && $past(gate_state[5+p])
      |-> $stable(pin_oe_n[p]) && $stable(pin_out[p])) else $error("gated port moved");
    a_gated_read: assert property (bus_req.rd && a == gpcg_pkg::GPCG_DIR_OFS[p]
      && gate_state[5+p] |=> rd_data == 8'h00) else $error("gated port answered");
  end
endmodule // gpcg_top_sva
bind gpcg_top gpcg_top_sva #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_sva (.clk(clk),
  .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .irq(irq), .gate_state(gate_state));
`default_nettype wire

// file: gpcg_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module gpcg_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  gpcg_pkg::gpcg_bus_req_t req = '0;
  gpcg_pkg::gpcg_drive_t [2:0] alt = {16'hA50F, 16'h00FF, 16'h00FF};
  logic [2:0][7:0] ext = {8'hFF, 8'hFF, 8'hFF};
  logic [2:0][7:0] pin_in, pin_out, pin_oe_n, alt_in, irq;
  logic [7:0] rd_data, gate_state, acc;
  int err_total = 0;
  int samples_checked = 0;
  initial forever #10 clk = ~clk;
  gpcg_top u_dut (.clk(clk), .rst(rst), .bus_req(req), .rd_data(rd_data), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_drive(alt), .alt_in(alt_in), .irq(irq),
    .gate_state(gate_state));
  gpcg_pin_model u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));
  function automatic logic [7:0] ofs(input int k, input int p);
    return k == 0 ? gpcg_pkg::GPCG_DATA_OFS[p] : k == 1 ? gpcg_pkg::GPCG_DIR_OFS[p] :
      k == 2 ? gpcg_pkg::GPCG_SELA_OFS[p] : gpcg_pkg::GPCG_SELB_OFS[p];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 chk(rd_data, exp);
  endtask
  // data first so edge modes are entered with the mode bit already set
  task automatic cfg(input int p, input logic [7:0] d, dir, sa, sb);
    wr(ofs(0, p), d);
    wr(ofs(3, p), sb);
    wr(ofs(2, p), sa);
    wr(ofs(1, p), dir);
    cyc(3);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ofs(1, 0), 8'hFF);
    rd(ofs(2, 0), 8'h00);
    rd(8'hDB, 8'h00);
    rd(ofs(0, 0), 8'hFF);
    chk(pin_oe_n[0], 8'hFF);
    for (int p = 0; p < 3; p++) begin
      cfg(p, 8'h32, 8'h64, 8'h78, 8'h80);
      chk(pin_oe_n[p], 8'hD4);
      chk(pin_out[p] & ~pin_oe_n[p], 8'h22);
      rd(ofs(0, p), 8'hF6);
    end
    cfg(2, 8'h00, 8'hFF, 8'h00, 8'hFF);
    cyc(2);
    chk(pin_oe_n[2], 8'h0F);
    chk(pin_out[2] & 8'hF0, 8'hA0);
    chk(alt_in[2], 8'hAF);
    @(posedge clk) ext[1] <= 8'h01;
    cfg(1, 8'h00, 8'hFF, 8'h00, 8'h00);
    cfg(1, 8'h0E, 8'hF2, 8'h0B, 8'h0F);
    chk(irq[1], 8'h00);
    @(posedge clk) ext[1] <= 8'h0F;
    cyc(5);
    chk(irq[1], 8'h0E);
    wr(ofs(0, 1), 8'h0E);
    cyc(2);
    chk(irq[1], 8'h08);
    @(posedge clk) ext[1] <= 8'h00;
    cyc(5);
    chk(irq[1], 8'h05);
    wr(ofs(0, 1), 8'h0A);
    cyc(2);
    chk(irq[1], 8'h05);
    wr(ofs(0, 1), 8'h0E);
    cyc(2);
    chk(irq[1], 8'h01);
    @(posedge clk) ext[1] <= 8'h08;
    @(posedge clk) ext[1] <= 8'h00;
    acc = 8'h00;
    repeat (6) begin
      cyc(1);
      acc = acc | irq[1];
    end
    chk(acc, 8'h01);
    chk(irq[0], 8'h00);
    wr(8'hDB, 8'h20);
    rd(ofs(1, 0), 8'h00);
    rd(ofs(1, 1), 8'hF2);
    wr(ofs(1, 0), 8'h00);
    wr(8'hDB, 8'hFF);
    rd(8'hDB, 8'hEF);
    rd(ofs(1, 2), 8'h00);
    wr(8'hDB, 8'h00);
    rd(ofs(1, 0), 8'h64);
    rd(8'h10, 8'h00);
    report_and_stop();
  end
endmodule // gpcg_tb_top
`default_nettype wire
